// ### core/tcap_top.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// R1 - Armed only with enable and arm set
// R2 - Disarm on end trigger or full begin
// R3 - Reset during end run clears arm only; the code also clears the break bit
// R4 - Arm write zero or disable clears armed
// R5 - Nine trigger modes qualify start or end
// R6 - Arming clears A, B, C flags
// R7 - A-only and A-or-B set matching flags
// R8 - A-then-B compares B after A
// R9 - Event B sets B, always begin
// R10 - A-then-event-B is begin type
// R11 - A-and-B sets both on joint match
// R12 - A-and-not-B sets both on condition
// R13 - Tagged end full modes trigger on A
// R14 - Inside range sets both flags
// R15 - Outside range sets holding comparator flag
// R16 - Run type from begin, select, break, tag
// R17 - Eight word queue, addresses or data
// R18 - Event words have zero upper byte
// R19 - Core flags indirect and branch flow
// R20 - Store address or previous minus two
// R21 - Begin run stores eight after trigger
// R22 - End run stops at trigger, no events
// R23 - Trigger flow address stored last
// R24 - End run keeps the newest eight
// R25 - Flags stay set until next arming
module tcap_top (
	// Clock and reset.
	input wire logic        clk,
	input wire logic        rstn,
	// APB slave.
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	output logic     [31:0] prdata,
	output logic            pready,
	output logic            pslverr,
	// Core buses and flow indicators, same clock.
	input wire logic [15:0] cpuAddr,
	input wire logic [7:0]  cpuData,
	input wire logic        busValid,
	input wire logic [1:0]  cofInd,
	input wire logic        opcodeExec,
	input wire logic        sysReset,
	// Break request to the core.
	output logic            breakReq,
	output logic            breakTag
);
	localparam int AW = tcap_pkg::ADDR_W;
	localparam int QD = tcap_pkg::QUEUE_DEPTH;

	logic [7:0]    ctrl_r;          // debug_control_reg.
	logic [7:0]    trig_r;          // debug_trigger_reg.
	logic [AW-1:0] cmpA_r;          // Comparator A value.
	logic [AW-1:0] cmpB_r;          // Comparator B value.
	logic [AW-1:0] cmpC_r;          // Comparator C value.
	logic          flagA_r;         // comp_a_flag.
	logic          flagB_r;         // comp_b_flag.
	logic          flagC_r;         // comp_c_flag.
	logic          aSeen_r;         // An A match has happened this run.
	logic [AW-1:0] prevAddr_r;      // Address of the previous bus cycle.
	logic [31:0]   prdata_r;        // Registered read data.
	logic          pready_r;        // High in the access phase.
	logic          pslverr_r;       // Unmapped address answer.
	logic          breakReq_r;      // One-cycle break request.
	logic          breakTag_r;      // Break is tag type.
	tcap_pkg::tcap_state_type state_r; // Trace run state.

	// Shared decode terms.
	logic          enable;          // module_enable.
	logic          armBit;          // Software arm bit.
	logic [3:0]    mode;            // Trigger mode.
	logic          evMode;          // Event-only mode.
	logic          beginRun;        // Effective begin type.
	logic          armed;           // armed_flag.
	logic          tagEnd;          // Tagged break on an end run.
	logic          accessDone;      // APB transfer completes this edge.
	logic          wrCtrl;          // Write to debug_control_reg.
	logic          armReq;          // Software arms the block.
	logic          sysEnd;          // Core reset ends an end run.
	logic          sysDef;          // Core reset restarts the default run.
	logic          clrFlags;        // Flags and A history clear.
	logic          mSetA;           // Raw A flag condition.
	logic          mSetB;           // Raw B flag condition.
	logic          mTrig;           // Raw trigger condition.
	logic          qual;            // Opcode and bus qualifier.
	logic          qSetA;           // Qualified A flag set.
	logic          qSetB;           // Qualified B flag set.
	logic          qTrig;           // Qualified trigger.
	logic          cofHit;          // A change of flow this cycle.
	logic [AW-1:0] cofWord;         // Address to store for it.
	logic          endHit;          // End run trigger disarms.
	logic          fullHit;         // Begin run queue full disarms.
	logic          disarmHw;        // Hardware ends the run.
	logic [31:0]   rdVal;           // Read mux.
	logic          rdErr;           // Read or write to no register.

	tcap_queue_if #(.W(AW), .D(QD)) qIf ();

	assign enable   = ctrl_r[tcap_pkg::CTRL_EN_BIT];
	assign armBit   = ctrl_r[tcap_pkg::CTRL_ARM_BIT];
	assign mode     = trig_r[3:0];
	assign evMode   = tcap_pkg::isEventMode(mode);
	// For arming and break type, event modes count as begin runs whatever the begin bit says.
	assign beginRun = trig_r[tcap_pkg::TRIG_BEGIN_BIT] | evMode; // R9 R10 R22
	assign armed    = (state_r != tcap_pkg::ST_IDLE);
	assign tagEnd   = ~beginRun & ctrl_r[tcap_pkg::CTRL_BRK_BIT] & ctrl_r[tcap_pkg::CTRL_TAG_BIT];

	// APB: the answer is registered in the setup cycle, so pready is high in
	// the first access cycle and writes land at that edge.
	assign accessDone = psel & penable & pready_r;
	assign wrCtrl     = accessDone & pwrite & (paddr == tcap_pkg::OFF_CTRL);
	// Arming needs both bits in the same write.
	assign armReq     = wrCtrl & pwdata[tcap_pkg::CTRL_EN_BIT] & pwdata[tcap_pkg::CTRL_ARM_BIT]
	                    & ~armed; // R1
	// A core reset while enabled with the begin bit clear only ends the run; otherwise it restarts.
	assign sysEnd   = sysReset & enable & ~trig_r[tcap_pkg::TRIG_BEGIN_BIT]; // R3
	assign sysDef   = sysReset & ~sysEnd;
	assign clrFlags = armReq | sysDef; // R6

	tcap_match #(.AW(AW), .DW(tcap_pkg::DATA_W)) uMatch (
		.mode   (mode),
		.cmpA   (cmpA_r),
		.cmpB   (cmpB_r),
		.aSeen  (aSeen_r),
		.tagEnd (tagEnd),
		.addr   (cpuAddr),
		.data   (cpuData),
		.setA   (mSetA),
		.setB   (mSetB),
		.trig   (mTrig)
	);

	tcap_queue #(.W(AW), .D(QD)) uQueue (
		.clk  (clk),
		.rstn (rstn),
		.q    (qIf)
	);

	// Trigger select waits for the opcode to execute, except in event modes.
	assign qual  = busValid & (~trig_r[tcap_pkg::TRIG_SEL_BIT] | evMode | opcodeExec);
	assign qSetA = armed & qual & mSetA;
	assign qSetB = armed & qual & mSetB;
	assign qTrig = armed & qual & mTrig;

	// Destination address for indirect flow, branch source otherwise.
	assign cofHit  = cofInd[1] | cofInd[0]; // R19
	assign cofWord = cofInd[1] ? cpuAddr : (prevAddr_r - tcap_pkg::COF_BACKSTEP); // R20

	// Hardware end of a run: trigger on an end run, full queue on a begin run.
	assign endHit   = (state_r == tcap_pkg::ST_END) & qTrig; // R22
	assign fullHit  = (state_r == tcap_pkg::ST_BEGIN) & qIf.full; // R21
	assign disarmHw = (endHit | fullHit) & enable & armBit; // R2

	// Queue feed. Begin runs store nothing before the trigger and never
	// overwrite; end runs keep storing, including the trigger's own flow.
	always_comb begin
		qIf.push     = 1'b0;
		qIf.pushData = cofWord;
		if (evMode) begin
			qIf.pushData = {tcap_pkg::EVT_UPPER, cpuData}; // R18
		end
		case (state_r)
			tcap_pkg::ST_WAIT: begin
				qIf.push = qTrig & (evMode | cofHit); // R21
			end
			tcap_pkg::ST_BEGIN: begin
				qIf.push = ~qIf.full & (evMode ? qSetB : cofHit); // R17 R21
			end
			tcap_pkg::ST_END: begin
				qIf.push = cofHit; // R23 R24
			end
			default: begin
				qIf.push = 1'b0;
			end
		endcase
	end
	assign qIf.clear = clrFlags;
	// Reading while armed returns the oldest word without shifting.
	assign qIf.pop   = accessDone & ~pwrite & (paddr == tcap_pkg::OFF_QUEUE) & ~armed;

	// Run state; disable or a cleared arm bit drops the armed flag at once.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= tcap_pkg::ST_WAIT;
		end else if (sysDef) begin
			state_r <= tcap_pkg::ST_WAIT;
		end else if (sysEnd) begin
			state_r <= tcap_pkg::ST_IDLE; // R3
		end else if (armReq) begin
			state_r <= beginRun ? tcap_pkg::ST_WAIT : tcap_pkg::ST_END; // R1 R16
		end else if (!enable || !armBit || disarmHw) begin
			state_r <= tcap_pkg::ST_IDLE; // R2 R4
		end else if (state_r == tcap_pkg::ST_WAIT && qTrig) begin
			state_r <= tcap_pkg::ST_BEGIN;
		end
	end

	// Control register; hardware clears the arm bit when a run ends.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_r <= tcap_pkg::CTRL_RST;
		end else if (sysDef) begin
			ctrl_r <= tcap_pkg::CTRL_RST;
		end else if (sysEnd) begin
			ctrl_r[tcap_pkg::CTRL_ARM_BIT] <= 1'b0; // R3
			ctrl_r[tcap_pkg::CTRL_BRK_BIT] <= 1'b0;
		end else if (wrCtrl) begin
			ctrl_r <= pwdata[7:0];
		end else if (disarmHw) begin
			ctrl_r[tcap_pkg::CTRL_ARM_BIT] <= 1'b0; // R2
		end
	end

	// Trigger and comparator registers.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			trig_r <= tcap_pkg::TRIG_RST;
			cmpA_r <= tcap_pkg::CMPA_RST;
			cmpB_r <= tcap_pkg::CMPB_RST;
			cmpC_r <= tcap_pkg::CMPC_RST;
		end else if (sysDef) begin
			trig_r <= tcap_pkg::TRIG_RST;
			cmpA_r <= tcap_pkg::CMPA_RST;
			cmpB_r <= tcap_pkg::CMPB_RST;
			cmpC_r <= tcap_pkg::CMPC_RST;
		end else if (accessDone && pwrite) begin
			case (paddr)
				tcap_pkg::OFF_TRIG: trig_r <= pwdata[7:0];
				tcap_pkg::OFF_CMPA: cmpA_r <= pwdata[15:0];
				tcap_pkg::OFF_CMPB: cmpB_r <= pwdata[15:0];
				tcap_pkg::OFF_CMPC: cmpC_r <= pwdata[15:0];
				default: begin
				end
			endcase
		end
	end

	// Match flags are sticky; a match in a software arming cycle cannot happen
	// because the block is not yet armed; in a core reset cycle a set wins over the clear.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flagA_r <= 1'b0;
			flagB_r <= 1'b0;
			flagC_r <= 1'b0;
			aSeen_r <= 1'b0;
		end else begin
			flagA_r <= (flagA_r & ~clrFlags) | qSetA; // R6 R25
			flagB_r <= (flagB_r & ~clrFlags) | qSetB; // R6 R25
			flagC_r <= (flagC_r & ~clrFlags) | (armed & busValid & (cpuAddr == cmpC_r));
			aSeen_r <= (aSeen_r & ~clrFlags) | qSetA; // R8
		end
	end

	// Previous bus cycle address for branch sources.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prevAddr_r <= '0;
		end else if (busValid) begin
			prevAddr_r <= cpuAddr; // R20
		end
	end

	// Break request: force type at a full begin run, tag or force at an end
	// trigger, never when breaks are disabled.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			breakReq_r <= 1'b0;
			breakTag_r <= 1'b0;
		end else begin
			breakReq_r <= disarmHw & ctrl_r[tcap_pkg::CTRL_BRK_BIT]; // R16
			breakTag_r <= disarmHw & endHit & tagEnd; // R16
		end
	end

	// Read mux and address decode.
	always_comb begin
		rdVal = 32'h0000_0000;
		rdErr = 1'b0;
		case (paddr)
			tcap_pkg::OFF_CTRL:  rdVal = {24'h00_0000, ctrl_r};
			tcap_pkg::OFF_TRIG:  rdVal = {24'h00_0000, trig_r};
			tcap_pkg::OFF_STAT:  rdVal = {24'h00_0000, flagA_r, flagB_r, flagC_r, 4'h0, armed};
			tcap_pkg::OFF_CMPA:  rdVal = {16'h0000, cmpA_r};
			tcap_pkg::OFF_CMPB:  rdVal = {16'h0000, cmpB_r};
			tcap_pkg::OFF_CMPC:  rdVal = {16'h0000, cmpC_r};
			tcap_pkg::OFF_COUNT: rdVal = {28'h000_0000, qIf.count};
			tcap_pkg::OFF_QUEUE: rdVal = {16'h0000, qIf.head};
			default: begin
				rdErr = 1'b1;
			end
		endcase
	end

	// APB answer, captured in the setup cycle.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= psel & ~penable;
			pslverr_r <= psel & ~penable & rdErr;
			if (psel && !penable && !pwrite) begin
				prdata_r <= rdVal;
			end
		end
	end

	assign prdata   = prdata_r;
	assign pready   = pready_r;
	assign pslverr  = pslverr_r;
	assign breakReq = breakReq_r;
	assign breakTag = breakTag_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_arm_cause: assert property ($rose(armed) |-> $past(armReq | sysDef)) // R1
		else $error("armed without enable and arm");
	a_end_stop: assert property (disarmHw && endHit && !sysReset && !wrCtrl |=> !armed && !armBit) // R2
		else $error("end trigger did not disarm");
	a_begin_full: assert property (fullHit && enable && armBit && !sysReset && !wrCtrl |=> !armed) // R21
		else $error("full begin run stayed armed");
	a_sysreset_end: assert property (sysEnd |=> !armed && !armBit) // R3
		else $error("core reset did not end run");
	a_disable_drop: assert property (!enable && !sysReset && !armReq |=> !armed) // R4
		else $error("disabled block still armed");
	a_arm_clears: assert property (armReq |=> !flagA_r && !flagB_r && !flagC_r && qIf.count == 0) // R6
		else $error("arming left flags or words");
	a_flag_sticky: assert property (flagA_r && !clrFlags |=> flagA_r) // R25
		else $error("flag A dropped without arming");
	a_event_upper: assert property (qIf.push && evMode |-> qIf.pushData[15:8] == 8'h00) // R18
		else $error("event word upper byte not zero");
	a_branch_back: assert property (qIf.push && !evMode && cofInd == 2'b01 // R20
		|-> qIf.pushData == $past(cpuAddr) - 16'h0002 || !$past(busValid))
		else $error("branch source not previous minus two");
	a_no_early: assert property (state_r == tcap_pkg::ST_WAIT && !qTrig |-> !qIf.push) // R21
		else $error("stored before begin trigger");
	a_queue_bound: assert property (qIf.count <= 4'h8) // R17
		else $error("queue count above eight");

	c_end_run: cover property (endHit ##1 !armed);
	c_begin_fill: cover property (fullHit && enable ##1 breakReq_r);
	c_event_store: cover property (qIf.push && evMode);
	c_sys_end: cover property (sysEnd);
endmodule
`default_nettype wire

// ### core/tcap_pkg.sv
`default_nettype none
// Shared constants for the trace trigger and capture block.
package tcap_pkg;

	// Bus widths and capture queue depth.
	localparam int ADDR_W      = 16;
	localparam int DATA_W      = 8;
	localparam int QUEUE_DEPTH = 8;

	// Register byte offsets on the APB port.
	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_TRIG  = 8'h04;
	localparam logic [7:0] OFF_STAT  = 8'h08;
	localparam logic [7:0] OFF_CMPA  = 8'h0c;
	localparam logic [7:0] OFF_CMPB  = 8'h10;
	localparam logic [7:0] OFF_CMPC  = 8'h14;
	localparam logic [7:0] OFF_COUNT = 8'h18;
	localparam logic [7:0] OFF_QUEUE = 8'h1c;

	// Field positions in debug_control_reg.
	localparam int CTRL_EN_BIT  = 7;
	localparam int CTRL_ARM_BIT = 6;
	localparam int CTRL_TAG_BIT = 5;
	localparam int CTRL_BRK_BIT = 4;

	// Field positions in debug_trigger_reg; the mode sits in bits 3:0.
	localparam int TRIG_SEL_BIT   = 7;
	localparam int TRIG_BEGIN_BIT = 6;

	// Reset values: an armed begin run on comparator A at the reset vector.
	localparam logic [7:0]  CTRL_RST = 8'hc0;
	localparam logic [7:0]  TRIG_RST = 8'h40;
	localparam logic [15:0] CMPA_RST = 16'hfffe;
	localparam logic [15:0] CMPB_RST = 16'h0000;
	localparam logic [15:0] CMPC_RST = 16'h0000;

	// Trigger mode codes.
	localparam logic [3:0] MODE_A_ONLY     = 4'h0;
	localparam logic [3:0] MODE_A_OR_B     = 4'h1;
	localparam logic [3:0] MODE_A_THEN_B   = 4'h2;
	localparam logic [3:0] MODE_EV_B       = 4'h3;
	localparam logic [3:0] MODE_A_THEN_EVB = 4'h4;
	localparam logic [3:0] MODE_A_AND_B    = 4'h5;
	localparam logic [3:0] MODE_A_NOT_B    = 4'h6;
	localparam logic [3:0] MODE_INSIDE     = 4'h7;
	localparam logic [3:0] MODE_OUTSIDE    = 4'h8;

	// Upper byte of an event word and the branch source step back.
	localparam logic [7:0]  EVT_UPPER    = 8'h00;
	localparam logic [15:0] COF_BACKSTEP = 16'h0002;

	// Trace run states.
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_BEGIN, ST_END} tcap_state_type;

	// True for the two modes that store data bus values.
	function automatic logic isEventMode(input logic [3:0] mode);
		return (mode == MODE_EV_B) || (mode == MODE_A_THEN_EVB);
	endfunction

	// True for the two modes where comparator B watches the data bus.
	function automatic logic isFullMode(input logic [3:0] mode);
		return (mode == MODE_A_AND_B) || (mode == MODE_A_NOT_B);
	endfunction

endpackage
`default_nettype wire

// ### core/tcap_queue_if.sv
`timescale 1ns/100ps
`default_nettype none
// Connection between the trace controller and its capture queue.
interface tcap_queue_if #(parameter int W = 16, parameter int D = 8);
	logic                 push;      // Store one word this cycle.
	logic [W-1:0]         pushData;  // Word to store.
	logic                 pop;       // Advance the read pointer.
	logic                 clear;     // Empty the queue.
	logic [W-1:0]         head;      // Oldest word.
	logic [$clog2(D+1)-1:0] count;   // Valid words, saturates at D.
	logic                 full;      // Count has reached D.
	modport owner (output push, pushData, pop, clear, input head, count, full);
	modport store (input push, pushData, pop, clear, output head, count, full);
endinterface
`default_nettype wire

// ### core/tcap_queue.sv
`timescale 1ns/100ps
`default_nettype none
// Circular capture queue that drops its oldest word when pushed while full.
module tcap_queue #(
	parameter int W = 16,
	parameter int D = 8
) (
	// Clock and reset.
	input wire logic   clk,
	input wire logic   rstn,
	// Controller side.
	tcap_queue_if.store q
);
	localparam int PW = $clog2(D);
	localparam int CW = $clog2(D+1);

	logic [W-1:0]  mem [D];   // Word storage, no reset needed.
	logic [PW-1:0] wrPtr_r;   // Next slot to write.
	logic [PW-1:0] rdPtr_r;   // Oldest slot.
	logic [CW-1:0] count_r;   // Valid words.

	// Pointers and count; a pop leaves the count alone so software still
	// sees how many words the run collected.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else if (q.clear) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else if (q.push) begin
			wrPtr_r <= wrPtr_r + PW'(1);
			if (count_r == CW'(D)) begin
				rdPtr_r <= rdPtr_r + PW'(1); // R24
			end else begin
				count_r <= count_r + CW'(1);
			end
		end else if (q.pop) begin
			rdPtr_r <= rdPtr_r + PW'(1);
		end
	end

	// Storage write.
	always_ff @(posedge clk) begin
		if (q.push) begin
			mem[wrPtr_r] <= q.pushData; // R17
		end
	end

	assign q.head  = mem[rdPtr_r];
	assign q.count = count_r;
	assign q.full  = (count_r == CW'(D));
endmodule
`default_nettype wire

// ### core/tcap_match.sv
`timescale 1ns/100ps
`default_nettype none
// Comparator decode: which flags a bus cycle sets and whether it triggers.
module tcap_match #(
	parameter int AW = 16,
	parameter int DW = 8
) (
	// Configuration.
	input wire logic [3:0]    mode,
	input wire logic [AW-1:0] cmpA,
	input wire logic [AW-1:0] cmpB,
	input wire logic          aSeen,
	input wire logic          tagEnd,
	// Core bus.
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] data,
	// Results.
	output logic              setA,
	output logic              setB,
	output logic              trig
);
	logic mA;   // Address equals comparator A.
	logic mB;   // Comparator B matches its bus.

	// In full modes B looks at the data bus, elsewhere at the address.
	assign mA = (addr == cmpA);
	assign mB = tcap_pkg::isFullMode(mode) ? (data == cmpB[DW-1:0]) : (addr == cmpB); // R11

	// Per mode flag and trigger decode.
	always_comb begin
		setA = 1'b0;
		setB = 1'b0;
		trig = 1'b0;
		case (mode) // R5
			tcap_pkg::MODE_A_ONLY: begin
				setA = mA; // R7
				trig = mA;
			end
			tcap_pkg::MODE_A_OR_B: begin
				setA = mA; // R7
				setB = mB;
				trig = mA | mB;
			end
			tcap_pkg::MODE_A_THEN_B, tcap_pkg::MODE_A_THEN_EVB: begin
				setA = mA; // R8 R10
				setB = mB & aSeen;
				trig = mB & aSeen;
			end
			tcap_pkg::MODE_EV_B: begin
				setB = mB; // R9
				trig = mB;
			end
			tcap_pkg::MODE_A_AND_B: begin
				setA = mA & mB; // R11
				setB = mA & mB;
				trig = tagEnd ? mA : (mA & mB); // R13
			end
			tcap_pkg::MODE_A_NOT_B: begin
				setA = mA & ~mB; // R12
				setB = mA & ~mB;
				trig = tagEnd ? mA : (mA & ~mB); // R13
			end
			tcap_pkg::MODE_INSIDE: begin
				setA = (addr >= cmpA) && (addr <= cmpB); // R14
				setB = setA;
				trig = setA;
			end
			tcap_pkg::MODE_OUTSIDE: begin
				setA = (addr < cmpA); // R15
				setB = (addr > cmpB);
				trig = setA | setB;
			end
			default: begin
				trig = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

// ### dv/tcap_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// Behavioural CPU core that drives bus cycles, flow indicators and reset events.
module tcap_core_model (
	// Clock.
	input wire logic    clk,
	// Core bus, indicators and reset event.
	output logic [15:0] cpuAddr,
	output logic [7:0]  cpuData,
	output logic        busValid,
	output logic [1:0]  cofInd,
	output logic        opcodeExec,
	output logic        sysReset
);
	// Idle at time zero; the bus holds a pattern, not a valid cycle.
	initial begin
		cpuAddr = 16'h5a5a;
		cpuData = 8'h5a;
		busValid = 1'b0;
		cofInd = 2'b00;
		opcodeExec = 1'b0;
		sysReset = 1'b0;
	end
	// One valid cycle; afterwards the bus shows the inverse so stale values never match.
	task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic [1:0] c);
		@(posedge clk);
		cpuAddr <= a;
		cpuData <= d;
		busValid <= 1'b1;
		cofInd <= c;
		opcodeExec <= 1'b1;
		@(posedge clk);
		cpuAddr <= ~a;
		cpuData <= ~d;
		busValid <= 1'b0;
		cofInd <= 2'b00;
		opcodeExec <= 1'b0;
	endtask
	// One-cycle core reset event.
	task automatic pulse();
		@(posedge clk);
		sysReset <= 1'b1;
		@(posedge clk);
		sysReset <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### dv/trace_trigger_capture_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// Register level bench: APB calls and core cycles with expected values.
module trace_trigger_capture_tb_top;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] cpuAddr;
	logic [7:0]  cpuData;
	logic        busValid;
	logic [1:0]  cofInd;
	logic        opcodeExec;
	logic        sysReset;
	logic        breakReq;
	logic        breakTag;
	int          n_fail = 0;
	int          checks_done = 0;
	int          brkCnt = 0;
	logic        brkTag = 1'b0;
	// Mode table: mode, address, data, expected A and B flags.
	localparam logic [31:0] TBL [13] = '{32'h0200_0002, 32'h1300_0001, 32'h2300_0000,
		32'h3300_0001, 32'h4300_0000, 32'h5200_0003, 32'h6200_0013, 32'h7300_0003,
		32'h8100_0002, 32'h5200_0010, 32'h6200_0000, 32'h8300_1001, 32'h71ff_f000};
	tcap_top DUT (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpuAddr(cpuAddr), .cpuData(cpuData), .busValid(busValid),
		.cofInd(cofInd), .opcodeExec(opcodeExec), .sysReset(sysReset),
		.breakReq(breakReq), .breakTag(breakTag));
	tcap_core_model core (.clk(clk), .cpuAddr(cpuAddr), .cpuData(cpuData),
		.busValid(busValid), .cofInd(cofInd), .opcodeExec(opcodeExec), .sysReset(sysReset));
	// 200 MHz clock.
	always #2.5 clk = ~clk;
	// Count break pulses; a pulse lasts one cycle, so each edge is one request.
	always @(posedge clk) begin
		if (breakReq === 1'b1) begin
			brkCnt <= brkCnt + 1;
			brkTag <= breakTag;
		end
	end
	// Closing task: verdict and end of run.
	task automatic report_and_stop();
		if (n_fail == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input bit ok, input string m);
		checks_done++;
		if (!ok) begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	// One APB transfer; the request holds until pready is seen high at an edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk({e, r} === {xe, x}, "register read mismatch");
	endtask
	// Main sequence.
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		rd(tcap_pkg::OFF_CTRL, 32'hc0, 1'b0);
		rd(tcap_pkg::OFF_TRIG, 32'h40, 1'b0);
		rd(tcap_pkg::OFF_CMPA, 32'hfffe, 1'b0);
		rd(tcap_pkg::OFF_STAT, 32'h01, 1'b0);
		rd(8'h20, 32'h0, 1'b1);
		// The vector fetch triggers the default begin run; eight words end it.
		core.cyc(16'hfffe, 8'h00, 2'b10);
		for (int i = 0; i < 7; i++) begin
			core.cyc(16'h0400 + 16'(i), 8'h00, 2'b10);
		end
		rd(tcap_pkg::OFF_STAT, 32'h80, 1'b0);
		rd(tcap_pkg::OFF_CTRL, 32'h80, 1'b0);
		rd(tcap_pkg::OFF_COUNT, 32'h08, 1'b0);
		rd(tcap_pkg::OFF_QUEUE, 32'hfffe, 1'b0);
		chk(brkCnt == 0, "break without break enable");
		// End run with break: overflow keeps only the newest eight words.
		wr(tcap_pkg::OFF_CMPA, 32'h1234);
		wr(tcap_pkg::OFF_TRIG, 32'h00);
		wr(tcap_pkg::OFF_CTRL, 32'hd0);
		rd(tcap_pkg::OFF_STAT, 32'h01, 1'b0);
		for (int i = 0; i < 10; i++) begin
			core.cyc(16'h0100 + 16'(i), 8'h00, 2'b10);
		end
		core.cyc(16'h0200, 8'h00, 2'b01);
		core.cyc(16'h1234, 8'h00, 2'b10);
		rd(tcap_pkg::OFF_STAT, 32'h80, 1'b0);
		rd(tcap_pkg::OFF_CTRL, 32'h90, 1'b0);
		chk(brkCnt == 1 && brkTag === 1'b0, "force break missing");
		rd(tcap_pkg::OFF_COUNT, 32'h08, 1'b0);
		for (int i = 0; i < 8; i++) begin
			rd(tcap_pkg::OFF_QUEUE, (i < 6) ? 32'h0104 + 32'(i) : ((i == 6) ? 32'h0107 : 32'h1234), 1'b0);
		end
		// Arming needs both bits; dropping either clears the armed flag.
		wr(tcap_pkg::OFF_CTRL, 32'h80);
		rd(tcap_pkg::OFF_STAT, 32'h80, 1'b0);
		wr(tcap_pkg::OFF_CTRL, 32'hc0);
		rd(tcap_pkg::OFF_STAT, 32'h01, 1'b0);
		wr(tcap_pkg::OFF_CTRL, 32'h80);
		rd(tcap_pkg::OFF_STAT, 32'h00, 1'b0);
		wr(tcap_pkg::OFF_CTRL, 32'hc0);
		wr(tcap_pkg::OFF_CTRL, 32'h40);
		rd(tcap_pkg::OFF_STAT, 32'h00, 1'b0);
		// A core reset in an end run only ends the run; otherwise defaults return.
		wr(tcap_pkg::OFF_CTRL, 32'hd0);
		core.pulse();
		rd(tcap_pkg::OFF_CTRL, 32'h80, 1'b0);
		rd(tcap_pkg::OFF_STAT, 32'h00, 1'b0);
		rd(tcap_pkg::OFF_CMPA, 32'h1234, 1'b0);
		wr(tcap_pkg::OFF_TRIG, 32'h41);
		core.pulse();
		rd(tcap_pkg::OFF_CTRL, 32'hc0, 1'b0);
		rd(tcap_pkg::OFF_TRIG, 32'h40, 1'b0);
		// Every mode once, then boundary cases: three that must set no flag and one just above B that sets B.
		wr(tcap_pkg::OFF_CMPA, 32'h2000);
		wr(tcap_pkg::OFF_CMPB, 32'h3000);
		for (int i = 0; i < 13; i++) begin
			wr(tcap_pkg::OFF_CTRL, 32'h80);
			wr(tcap_pkg::OFF_TRIG, 32'h40 | {28'h0, TBL[i][31:28]});
			wr(tcap_pkg::OFF_CTRL, 32'hc0);
			core.cyc(TBL[i][27:12], TBL[i][11:4], 2'b00);
			rd(tcap_pkg::OFF_STAT, {24'h0, TBL[i][1:0], 6'h01}, 1'b0);
		end
		// Tagged end run in a full mode ends on A alone; only the C flag is set.
		wr(tcap_pkg::OFF_CTRL, 32'h80);
		wr(tcap_pkg::OFF_CMPC, 32'h2000);
		wr(tcap_pkg::OFF_TRIG, 32'h85);
		wr(tcap_pkg::OFF_CTRL, 32'hf0);
		core.cyc(16'h2000, 8'h01, 2'b00);
		rd(tcap_pkg::OFF_STAT, 32'h20, 1'b0);
		chk(brkCnt == 2 && brkTag === 1'b1, "tag break missing");
		// Event data words carry a zero upper byte.
		wr(tcap_pkg::OFF_CTRL, 32'h80);
		wr(tcap_pkg::OFF_TRIG, 32'h43);
		wr(tcap_pkg::OFF_CTRL, 32'hc0);
		for (int i = 0; i < 8; i++) begin
			core.cyc(16'h3000, 8'ha5, 2'b00);
		end
		rd(tcap_pkg::OFF_STAT, 32'h40, 1'b0);
		rd(tcap_pkg::OFF_QUEUE, 32'h00a5, 1'b0);
		report_and_stop();
	end
	// Watchdog: the sequence needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		$display("CHECK FAILED at %0t: timeout", $time);
		report_and_stop();
	end
endmodule
`default_nettype wire
